// ==== wrs_pkg.sv ====
/*
   Package for the watchdog reset-status block: register indices and byte
   addresses, field positions, reset values and the packed state record.
   Assumes a 32-bit APB master and a single system clock.
*/
package wrs_pkg;

   // Register indices (byte address is four times the index)
   localparam logic [7:0]  IDX_COUNT      = 8'hA8;
   localparam logic [7:0]  IDX_RST_CTRL   = 8'hAA;
   localparam logic [11:0] ADDR_COUNT     = 12'h2A0;
   localparam logic [11:0] ADDR_RST_CTRL  = 12'h2A8;
   // Block-local registers
   localparam logic [11:0] ADDR_TMR_CTRL  = 12'h2B0;
   localparam logic [11:0] ADDR_IRQ_STAT  = 12'h2B4;
   localparam logic [11:0] ADDR_IRQ_MASK  = 12'h2B8;

   // Field positions
   localparam int FLAG_BIT      = 7;   // Flag in both control registers
   localparam int RST_OUT_EN_BIT = 6;
   localparam int MODE_BIT      = 6;   // 1: watchdog, 0: interval
   localparam int ENABLE_BIT    = 5;
   localparam int IRQ_OVERFLOW  = 0;
   localparam int IRQ_WD_RESET  = 1;

   // Values after reset and fixed read bits
   localparam logic [7:0] COUNT_RST     = 8'h00;
   localparam logic [7:0] COUNT_MAX     = 8'hFF;
   localparam logic [7:0] RST_CTRL_ONES = 8'h3F;
   localparam logic [7:0] TMR_CTRL_ONES = 8'h18;
   localparam logic [2:0] CKS_RST       = 3'h0;
   localparam logic [1:0] IRQ_RST       = 2'h0;

   typedef struct packed {
      logic [7:0]  count;
      logic        wd_reset_flag;
      logic        rst_out_en;
      logic        overflow_flag;
      logic        wd_mode;
      logic        tme;
      logic [2:0]  cks;
      logic        arm_wd_reset;
      logic        arm_overflow;
      logic [1:0]  irq_stat;
      logic [1:0]  irq_mask;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
      logic        wd_reset;
      logic        rst_out;
   } wrs_state_t;

endpackage

// ==== wrs_pin_sync.sv ====
/*
   Three-stage synchroniser for a pin level with agreement filter.
   Assumes the pin is asynchronous to mclk_i; idles high.
*/
`timescale 1ns/1ns
module wrs_pin_sync
   import wrs_pkg::*;
(
   input  wire logic mclk_i,
   input  wire logic nrst_i,
   input  wire logic pin_i,
   output logic      level_o
);

   logic [2:0] sync;

   ////////////////////////////////////////////////////////////////////////
   // First stage only feeds the second; level moves when 2 and 3 agree
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sync    <= 3'h7;
         level_o <= 1'b1;
      end
      else
      begin
         sync <= {sync[1:0], pin_i};
         if (sync[1] == sync[2])
         begin
            level_o <= sync[2];
         end
      end
   end

endmodule

// ==== wrs_watchdog.sv ====
/*
   Watchdog counter with reset reporting, reached over APB.
   Assumes count_tick_i is a one-cycle prescaler pulse on mclk_i and
   ext_rst_n_i is the raw external reset pin.
*/
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
module wrs_watchdog
   import wrs_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        nrst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        count_tick_i,
   input  wire logic        ext_rst_n_i,
   output logic             irq_o,
   output logic             wd_reset_o,
   output logic             rst_out_o
);

   wrs_state_t st;
   wrs_state_t next_st;
   logic       pin_level;
   logic       access;
   logic       wr_en;
   logic       rd_en;
   logic       wrap;
   logic       wd_event;

   // Address decode shared by read mux, write and error paths
   function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
      hit = (a == reg_addr);
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      mapped = hit(a, ADDR_COUNT) | hit(a, ADDR_RST_CTRL) | hit(a, ADDR_TMR_CTRL)
             | hit(a, ADDR_IRQ_STAT) | hit(a, ADDR_IRQ_MASK);
   endfunction

   wrs_pin_sync wrs_pin_sync_i
   (
      .mclk_i  (mclk_i),
      .nrst_i  (nrst_i),
      .pin_i   (ext_rst_n_i),
      .level_o (pin_level)
   );

   ////////////////////////////////////////////////////////////////////////
   // Transfer completes where pready is seen high in the access phase
   assign access   = psel_i & penable_i & st.pready;
   assign wr_en    = access & pwrite_i;
   assign rd_en    = access & ~pwrite_i;
   assign wrap     = st.tme & count_tick_i & (st.count == COUNT_MAX);
   assign wd_event = wrap & st.wd_mode;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic; hardware sets are applied last so they win
   always_comb
   begin
      next_st = st;
      // No wait state: pready rises in the first access cycle
      next_st.pready  = psel_i & ~penable_i;
      next_st.pslverr = psel_i & ~penable_i & ~mapped(paddr_i);
      next_st.prdata  = 32'h0000_0000;
      if (psel_i & ~penable_i & ~pwrite_i)
      begin
         if (hit(paddr_i, ADDR_COUNT))
            next_st.prdata[7:0] = st.count;
         else if (hit(paddr_i, ADDR_RST_CTRL))
            next_st.prdata[7:0] = RST_CTRL_ONES | {st.wd_reset_flag, st.rst_out_en, 6'h00};
         else if (hit(paddr_i, ADDR_TMR_CTRL))
            next_st.prdata[7:0] = TMR_CTRL_ONES | {st.overflow_flag, st.wd_mode, st.tme, 2'h0, st.cks};
         else if (hit(paddr_i, ADDR_IRQ_STAT))
            next_st.prdata[1:0] = st.irq_stat;
         else if (hit(paddr_i, ADDR_IRQ_MASK))
            next_st.prdata[1:0] = st.irq_mask;
      end

      // Counter: halted at zero while disabled
      if (!st.tme)
         next_st.count = COUNT_RST;
      else if (count_tick_i)
         next_st.count = 8'(st.count + 8'h01);

      // arm on a read that returned the flag as 1
      if (rd_en && hit(paddr_i, ADDR_RST_CTRL) && st.prdata[FLAG_BIT])
         next_st.arm_wd_reset = 1'b1;
      if (rd_en && hit(paddr_i, ADDR_TMR_CTRL) && st.prdata[FLAG_BIT])
         next_st.arm_overflow = 1'b1;

      if (wr_en)
      begin
         if (hit(paddr_i, ADDR_COUNT))
            next_st.count = pwdata_i[7:0];
         if (hit(paddr_i, ADDR_RST_CTRL))
         begin
            next_st.rst_out_en = pwdata_i[RST_OUT_EN_BIT];
            // only a written 0 after an armed read clears
            if (!pwdata_i[FLAG_BIT] && st.arm_wd_reset)
               next_st.wd_reset_flag = 1'b0;
            next_st.arm_wd_reset = 1'b0;
         end
         if (hit(paddr_i, ADDR_TMR_CTRL))
         begin
            next_st.wd_mode = pwdata_i[MODE_BIT];
            next_st.tme     = pwdata_i[ENABLE_BIT];
            next_st.cks     = pwdata_i[2:0];
            if (!pwdata_i[FLAG_BIT] && st.arm_overflow)
               next_st.overflow_flag = 1'b0;
            next_st.arm_overflow = 1'b0;
         end
         if (hit(paddr_i, ADDR_IRQ_STAT))
            next_st.irq_stat = st.irq_stat & ~pwdata_i[1:0];
         if (hit(paddr_i, ADDR_IRQ_MASK))
            next_st.irq_mask = pwdata_i[1:0];
      end

      // external pin reset clears the flag
      // A same-cycle watchdog overflow below still wins over this clear
      if (!pin_level)
      begin
         next_st.wd_reset_flag = 1'b0;
         next_st.arm_wd_reset  = 1'b0;
      end

      if (wrap)
      begin
         next_st.overflow_flag          = 1'b1;
         next_st.irq_stat[IRQ_OVERFLOW] = 1'b1;
      end
      // watchdog overflow sets flag and fires reset
      if (wd_event)
      begin
         next_st.wd_reset_flag          = 1'b1;
         next_st.irq_stat[IRQ_WD_RESET] = 1'b1;
      end
      next_st.wd_reset = wd_event;
      // drive the pin only when enabled
      next_st.rst_out  = wd_event & st.rst_out_en;
      next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         st          <= '0;
         st.count    <= COUNT_RST;
         st.cks      <= CKS_RST;
         st.irq_stat <= IRQ_RST;
         st.irq_mask <= IRQ_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign prdata_o   = st.prdata;
   assign pready_o   = st.pready;
   assign pslverr_o  = st.pslverr;
   assign irq_o      = st.irq;
   assign wd_reset_o = st.wd_reset;
   assign rst_out_o  = st.rst_out;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   // Flag set and clear paths
   a_wd_overflow_reset: assert property (wd_event |=> st.wd_reset_flag && wd_reset_o)
      else $error("watchdog overflow did not set flag and reset");
   a_pin_clear_flag: assert property ((!pin_level && !wd_event) |=> !st.wd_reset_flag)
      else $error("pin reset did not clear flag");
   a_clear_needs_read: assert property ((wr_en && hit(paddr_i, ADDR_RST_CTRL) && !st.arm_wd_reset
                                         && st.wd_reset_flag && pin_level) |=> st.wd_reset_flag)
      else $error("flag cleared without prior read");
   a_write_one_ignored: assert property ((wr_en && hit(paddr_i, ADDR_RST_CTRL) && pwdata_i[FLAG_BIT]
                                          && pin_level && !wd_event)
                                         |=> st.wd_reset_flag == $past(st.wd_reset_flag))
      else $error("writing one changed the flag");

   // Reset outputs; back-to-back overflows may legally pulse twice
   a_rst_out_gated: assert property (wd_event |=> rst_out_o == $past(st.rst_out_en))
      else $error("reset output does not follow enable");
   a_rst_out_quiet: assert property (!wd_event |=> !rst_out_o && !wd_reset_o)
      else $error("reset pulse without watchdog overflow");

   // Counter, bus and interrupt
   a_wrap_overflow: assert property ((wrap && !(wr_en && hit(paddr_i, ADDR_COUNT)))
                                     |=> st.count == COUNT_RST && st.overflow_flag)
      else $error("wrap did not zero count and set overflow");
   a_count_halted: assert property ((!st.tme && !(wr_en && hit(paddr_i, ADDR_COUNT)))
                                    |=> st.count == COUNT_RST)
      else $error("disabled counter moved");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready held longer than one cycle");
   a_irq_level: assert property (irq_o == |(st.irq_stat & st.irq_mask))
      else $error("interrupt output mismatch");

   c_wd_reset: cover property (wd_event ##1 rst_out_o);
   c_sw_clear: cover property (st.wd_reset_flag && wr_en && hit(paddr_i, ADDR_RST_CTRL) && st.arm_wd_reset);
   c_interval: cover property (wrap && !st.wd_mode);
   c_pin_clear: cover property (st.wd_reset_flag && !pin_level);
   c_irq_raise: cover property (!irq_o ##1 irq_o);

endmodule

// ==== wrs_watchdog_bench.sv ====
/*
   Self-checking bench for the watchdog reset-status block.
   Assumes an APB slave that raises pready when done; no partner model.
*/
`timescale 1ns/1ns
module wrs_watchdog_bench
   import wrs_pkg::*;
;

   logic        mclk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        psel, penable, pwrite, tick, ext_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic        pready, pslverr, irq, wdr, rso, e;
   int          miscompares = 0;
   int          cmp_count = 0;
   int          wd_n, ro_n;
   // Register map at reset, unmapped word last
   logic [11:0] ra[6] = '{ADDR_COUNT, ADDR_RST_CTRL, ADDR_TMR_CTRL, ADDR_IRQ_STAT, ADDR_IRQ_MASK, 12'h2BC};
   logic [31:0] rd[6] = '{32'h00, 32'h3F, 32'h18, 32'h00, 32'h00, 32'h00};
   logic        re[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and pulse counters
   always #2 mclk_i = ~mclk_i;
   always @(posedge mclk_i)
   begin
      wd_n += (wdr === 1'b1);
      ro_n += (rso === 1'b1);
   end

   wrs_watchdog wrs_watchdog_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .count_tick_i(tick), .ext_rst_n_i(ext_n), .irq_o(irq), .wd_reset_o(wdr),
      .rst_out_o(rso));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One APB transfer; idle edge after release keeps drivers apart
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      // Wait for the slave; only the run watchdog ends a hang
      do
      begin
         @(posedge mclk_i);
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk_i);
   endtask

   task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, exp, r);
   endtask

   // Load count FE and tick twice, so the counter wraps once
   task automatic wrap(input logic [7:0] ctl);
      apb(1'b1, ADDR_TMR_CTRL, {24'h0, ctl});
      apb(1'b1, ADDR_COUNT, 32'hFE);
      wd_n = 0;
      ro_n = 0;
      tick <= 1'b1;
      repeat (2) @(posedge mclk_i);
      tick <= 1'b0;
      repeat (4) @(posedge mclk_i);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog against hangs
   initial
   begin
      #40000;
      miscompares++;
      end_sim();
   end

   initial
   begin
      {psel, penable, pwrite, tick} = 4'h0;
      ext_n = 1'b1;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (12) @(posedge mclk_i);
      chk("reset pulse", 32'h0, {30'h0, wdr, rso});
      chk("reset outputs", 32'h0, {29'h0, pslverr, pready, irq});
      chk("reset read data", 32'h0, prdata);
      nrst_i <= 1'b1;
      @(posedge mclk_i);
      chk("release outputs", 32'h0, {27'h0, pslverr, pready, irq, wdr, rso});
      for (int i = 0; i < 6; i++)
      begin
         rdchk("reset read", ra[i], rd[i]);
         chk("slave error", {31'h0, re[i]}, {31'h0, e});
      end
      apb(1'b1, ADDR_RST_CTRL, 32'h40);
      wrap(8'h60);
      chk("reset pulses", 32'h1, wd_n);
      chk("pin pulses", 32'h1, ro_n);
      rdchk("count", ADDR_COUNT, 32'h00);
      rdchk("timer status", ADDR_TMR_CTRL, 32'hF8);
      apb(1'b1, ADDR_RST_CTRL, 32'h40);
      rdchk("flag unread", ADDR_RST_CTRL, 32'hFF);
      apb(1'b1, ADDR_RST_CTRL, 32'hC0);
      rdchk("flag one", ADDR_RST_CTRL, 32'hFF);
      apb(1'b1, ADDR_RST_CTRL, 32'h40);
      rdchk("flag clear", ADDR_RST_CTRL, 32'h7F);
      apb(1'b1, ADDR_RST_CTRL, 32'hC0);
      rdchk("flag stays clear", ADDR_RST_CTRL, 32'h7F);
      apb(1'b1, ADDR_IRQ_MASK, 32'h2);
      chk("irq set", 32'h1, {31'h0, irq});
      apb(1'b1, ADDR_IRQ_STAT, 32'h2);
      chk("irq clear", 32'h0, {31'h0, irq});
      rdchk("irq status", ADDR_IRQ_STAT, 32'h1);
      apb(1'b1, ADDR_RST_CTRL, 32'h00);
      wrap(8'h60);
      chk("reset pulses", 32'h1, wd_n);
      chk("pin quiet", 32'h0, ro_n);
      chk("irq watchdog", 32'h1, {31'h0, irq});
      rdchk("flag set", ADDR_RST_CTRL, 32'hBF);
      ext_n <= 1'b0;
      repeat (8) @(posedge mclk_i);
      ext_n <= 1'b1;
      repeat (8) @(posedge mclk_i);
      rdchk("pin clear", ADDR_RST_CTRL, 32'h3F);
      wrap(8'h20);
      chk("interval pulses", 32'h0, wd_n);
      rdchk("interval flag", ADDR_RST_CTRL, 32'h3F);
      rdchk("interval overflow", ADDR_TMR_CTRL, 32'hB8);
      // Reset in mid-run clears every output and the count, timer, control and status registers
      nrst_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      chk("mid reset outputs", 32'h0, {27'h0, pslverr, pready, irq, wdr, rso});
      nrst_i <= 1'b1;
      @(posedge mclk_i);
      rdchk("mid reset count", ADDR_COUNT, 32'h00);
      rdchk("mid reset timer", ADDR_TMR_CTRL, 32'h18);
      rdchk("mid reset control", ADDR_RST_CTRL, 32'h3F);
      rdchk("mid reset status", ADDR_IRQ_STAT, 32'h00);
      end_sim();
   end
endmodule
